// >>> common/pad_port_pkg.sv
// package: register selects, field layouts, reset values and oscillator codes for pad/port A logic
package pad_port_pkg;
	// register select codes on the special-function register port
	localparam logic [3:0] SEL_NONE       = 4'h0;
	localparam logic [3:0] SEL_PORT_PINS  = 4'h1;
	localparam logic [3:0] SEL_PORT_DIR   = 4'h2;
	localparam logic [3:0] SEL_PORT_LATCH = 4'h3;
	localparam logic [3:0] SEL_INT_CTRL_TWO = 4'h4;
	localparam logic [3:0] SEL_PORT_G       = 4'h5;
	localparam logic [3:0] SEL_WDOG_CTRL    = 4'h6;
	localparam logic [3:0] SEL_TIMER1_LOW   = 4'h7;
	localparam logic [3:0] SEL_TIMER1_HIGH  = 4'h8;
	localparam logic [3:0] SEL_TIMER1_CTRL  = 4'h9;
	localparam logic [3:0] SEL_TIMER2_COUNT = 4'hA;
	localparam logic [3:0] SEL_ANALOG0    = 4'hB;

	// field positions
	localparam int PULLUP_B_BIT   = 7;
	localparam int PULLUP_D_BIT   = 7;
	localparam int PULLUP_E_BIT   = 6;
	localparam int PULLUP_J_BIT   = 5;
	localparam int SHARED_SEL_BIT = 4;
	localparam int PARALLEL_TTL_BIT = 0;
	localparam int TIMER0_PIN     = 4;

	// writable masks and reset values
	localparam logic [7:0] CAPTURE_OD_MASK  = 8'h1F;
	localparam logic [7:0] SERIAL_OD_MASK   = 8'h03;
	localparam logic [7:0] SPI_OD_MASK      = 8'h03;
	localparam logic [7:0] PAD_BUF_MASK     = 8'h01;
	localparam logic [7:0] OD_RESET         = 8'h00;
	localparam logic [7:0] DIR_RESET        = 8'hFF;
	localparam logic [7:0] LATCH_RESET      = 8'h00;
	localparam logic [7:0] ANALOG_RESET     = 8'h00;
	localparam logic [7:0] INT_CTRL_TWO_RESET = 8'hFF;
	localparam logic [7:0] PORT_G_UP_RESET    = 8'h00;
	localparam logic [7:0] WDOG_CTRL_RESET    = 8'h00;
	localparam logic [7:0] UPPER_PORT_MASK  = 8'hE0;
	localparam logic [7:0] LOW_PORT_MASK    = 8'h3F;
	localparam logic [1:0] QUARTER_DIV_LAST = 2'h1;

	// oscillator mode codes
	localparam logic [2:0] OSC_INT_PLL_CLKOUT = 3'h3;
	localparam logic [2:0] OSC_INT_PLL_IO     = 3'h2;
	localparam logic [2:0] OSC_INT_CLKOUT     = 3'h1;
	localparam logic [2:0] OSC_INT_IO         = 3'h0;

	typedef struct packed {
		logic [3:0] sel;
		logic       wr;
		logic [7:0] wdata;
	} sfr_req_t;

	typedef struct packed {
		logic [7:0] out;
		logic [7:0] oe;
	} pad_drive_t;
endpackage

// >>> src/pad_port_ctrl.sv
// pad configuration registers and first general-purpose port control
`timescale 1ns/10ps
//
// Behaviour
// R01: weak pull-ups on four ports
// R02: port B enable control-two bit 7, others G<7:5>
// R03: port J enable only on large package
// R04: open-drain only on listed peripheral outputs
// R05: shared select bit gates open-drain registers
// R06: pad register replaces timer2 when selected
// R07: bit 0 selects TTL for parallel port
// R08: capture open-drain bits 4:0, rest zero
// R09: serial open-drain bits 1:0, rest zero
// R10: spi open-drain bits 1:0, rest zero
// R11: six-bit port, direction and latch
// R12: reset makes pins 5,3:0 analog, read zero
// R13: analog config chooses analog or digital
// R14: direction bits still drive analog pins
// R15: pin 4 Schmitt, others TTL push-pull
// R16: external oscillator hides pins 6,7
// R17: internal codes choose clock-out or I/O
// R18: pin 6 clock out at quarter rate
// R19: pins 6,7 bits defined only as I/O
// R20: port read gives pins, write sets latch
// R21: direction one input, zero drives latch
// R22: open-drain drives low only
// R23: pull-up only while pin is input
module pad_port_ctrl
	import pad_port_pkg::*;
#(
	parameter bit LARGE_PACKAGE = 1'b1
)(
	// clock, reset, enable
	input  wire logic       core_clk,
	input  wire logic       rst,
	input  wire logic       clkEn,
	// special-function register port
	input  wire sfr_req_t   sfrReq,
	output logic [7:0]      sfrRdata,
	output logic            sfrHit,
	// configuration and oscillator
	input  wire logic [2:0] oscillator_mode_code,
	// first port pads
	input  wire logic [7:0] padIn,
	output pad_drive_t      padDrive,
	output logic [5:0]      pullupEnA,
	output logic            timer0_clock_input,
	// open-drain gating for peripheral outputs
	input  wire logic [4:0] captureOut,
	input  wire logic [1:0] serialOut,
	input  wire logic [1:0] spiOut,
	output logic [4:0]      captureOe,
	output logic [1:0]      serialOe,
	output logic [1:0]      spiOe,
	input  wire logic [4:0] captureDirOut,
	input  wire logic [1:0] serialDirOut,
	input  wire logic [1:0] spiDirOut,
	// pull-up and buffer controls to other ports, and the pin 4 Schmitt select
	output logic            port_b_pullup_enable_n,
	output logic            port_d_pullup_enable,
	output logic            port_e_pullup_enable,
	output logic            port_j_pullup_enable,
	output logic            parallel_port_ttl_select,
	output logic            schmittSelA4
);

	////////////////////////////////////////////////////////////////////////
	logic [7:0] captureOd_r, serialOd_r, spiOd_r, padBuf_r;
	logic [7:0] dir_r, latch_r, analog_r, intCtrlTwo_r, portGUp_r, wdogCtrl_r;
	logic [7:0] pinSync1_r, pinSync2_r;
	logic [7:0] rdata_nxt;
	logic [1:0] quarterDiv_r;
	logic       quarterClk_r;

	wire logic shared_register_select = wdogCtrl_r[SHARED_SEL_BIT];
	wire logic wrEn   = clkEn & sfrReq.wr;
	wire logic internal_oscillator_mode = ~oscillator_mode_code[2];
	// pin 6 gives clock out for odd internal codes
	wire logic pin6ClkOut = internal_oscillator_mode & oscillator_mode_code[0]; // [R17]
	wire logic pin6Io = internal_oscillator_mode & ~oscillator_mode_code[0]; // [R16] [R17]
	wire logic pin7Io = internal_oscillator_mode; // [R16] [R17]
	wire logic [7:0] ioMask = {pin7Io, pin6Io, LOW_PORT_MASK[5:0]}; // [R19]
	// analog bit 1 = digital; pin 4 has no analog function
	wire logic [7:0] digMask = {2'b11, analog_r[4], 1'b1, analog_r[3:0]}; // [R12] [R13]
	wire logic [7:0] dirView = dir_r & ioMask; // [R16]
	wire logic [7:0] latchView = latch_r & ioMask; // [R16]
	wire logic [7:0] pinView = pinSync2_r & ioMask & digMask; // [R12] [R20]

	wire logic selOd1 = shared_register_select & (sfrReq.sel == SEL_TIMER1_LOW); // [R05]
	wire logic selOd2 = shared_register_select & (sfrReq.sel == SEL_TIMER1_HIGH); // [R05]
	wire logic selOd3 = shared_register_select & (sfrReq.sel == SEL_TIMER1_CTRL); // [R05]
	wire logic selPad = shared_register_select & (sfrReq.sel == SEL_TIMER2_COUNT); // [R06]
	wire logic selAn  = shared_register_select & (sfrReq.sel == SEL_ANALOG0);
	wire logic selPins  = sfrReq.sel == SEL_PORT_PINS;
	wire logic selDir   = sfrReq.sel == SEL_PORT_DIR;
	wire logic selLatch = sfrReq.sel == SEL_PORT_LATCH;
	wire logic selIc2   = sfrReq.sel == SEL_INT_CTRL_TWO;
	wire logic selPg    = sfrReq.sel == SEL_PORT_G;
	wire logic selWdt   = sfrReq.sel == SEL_WDOG_CTRL;
	wire logic [7:0] pgMask = LARGE_PACKAGE ? UPPER_PORT_MASK
		: (UPPER_PORT_MASK & ~(8'h01 << PULLUP_J_BIT)); // [R03]

	////////////////////////////////////////////////////////////////////////
	// registers; shared-space ones answer only with the select bit set
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			captureOd_r <= OD_RESET; // [R08]
			serialOd_r  <= OD_RESET; // [R09]
			spiOd_r     <= OD_RESET; // [R10]
			padBuf_r    <= OD_RESET; // [R07]
			dir_r       <= DIR_RESET;
			latch_r     <= LATCH_RESET;
			analog_r    <= ANALOG_RESET; // [R12]
			intCtrlTwo_r <= INT_CTRL_TWO_RESET;
			portGUp_r    <= PORT_G_UP_RESET;
			wdogCtrl_r   <= WDOG_CTRL_RESET;
		end
		else if (wrEn)
		begin
			if (selOd1)
				captureOd_r <= sfrReq.wdata & CAPTURE_OD_MASK; // [R08]
			if (selOd2)
				serialOd_r <= sfrReq.wdata & SERIAL_OD_MASK; // [R09]
			if (selOd3)
				spiOd_r <= sfrReq.wdata & SPI_OD_MASK; // [R10]
			if (selPad)
				padBuf_r <= sfrReq.wdata & PAD_BUF_MASK; // [R07]
			if (selAn)
				analog_r <= sfrReq.wdata; // [R13]
			if (selDir)
				dir_r <= sfrReq.wdata; // [R11]
			if (selPins | selLatch)
				latch_r <= sfrReq.wdata; // [R20]
			if (selIc2)
				intCtrlTwo_r <= sfrReq.wdata; // [R02]
			if (selPg)
				portGUp_r <= sfrReq.wdata & pgMask; // [R02] [R03]
			if (selWdt)
				wdogCtrl_r <= sfrReq.wdata;
		end
	end

	// two-stage pin synchroniser
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			pinSync1_r <= 8'h00;
			pinSync2_r <= 8'h00;
		end
		else if (clkEn)
		begin
			pinSync1_r <= padIn;
			pinSync2_r <= pinSync1_r;
		end
	end

	// quarter-rate clock: toggles every two cycles of core clock
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			quarterDiv_r <= 2'h0;
			quarterClk_r <= 1'b0;
		end
		else if (clkEn)
		begin
			quarterDiv_r <= (quarterDiv_r == QUARTER_DIV_LAST) ? 2'h0 : quarterDiv_r + 2'h1;
			if (quarterDiv_r == QUARTER_DIV_LAST)
				quarterClk_r <= ~quarterClk_r; // [R18]
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read mux; unshared addresses belong to timers, so no hit here
	always_comb
	begin
		rdata_nxt = 8'h00;
		unique case (1'b1)
			selOd1:   rdata_nxt = captureOd_r;
			selOd2:   rdata_nxt = serialOd_r;
			selOd3:   rdata_nxt = spiOd_r;
			selPad:   rdata_nxt = padBuf_r;
			selAn:    rdata_nxt = analog_r;
			selPins:  rdata_nxt = pinView; // [R20]
			selDir:   rdata_nxt = dirView;
			selLatch: rdata_nxt = latchView;
			selIc2:   rdata_nxt = intCtrlTwo_r;
			selPg:    rdata_nxt = portGUp_r;
			selWdt:   rdata_nxt = wdogCtrl_r;
			default:  rdata_nxt = 8'h00;
		endcase
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			sfrRdata <= 8'h00;
			sfrHit   <= 1'b0;
		end
		else if (clkEn)
		begin
			sfrRdata <= rdata_nxt;
			sfrHit   <= selOd1 | selOd2 | selOd3 | selPad | selAn | selPins | selDir
				| selLatch | selIc2 | selPg | selWdt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// port A drivers: direction keeps control even in analog use
	genvar i;
	generate
		for (i = 0; i < 8; i++)
		begin : g_pad
			if (i == 6)
			begin : g_p6
				assign padDrive.out[i] = pin6ClkOut ? quarterClk_r : latch_r[i]; // [R18]
				assign padDrive.oe[i]  = pin6ClkOut | (pin6Io & ~dir_r[i]); // [R21]
			end
			else if (i == 7)
			begin : g_p7
				assign padDrive.out[i] = latch_r[i];
				assign padDrive.oe[i]  = pin7Io & ~dir_r[i]; // [R16] [R21]
			end
			else
			begin : g_plain
				assign padDrive.out[i] = latch_r[i]; // [R15]
				assign padDrive.oe[i]  = ~dir_r[i]; // [R14] [R21]
			end
		end
	endgenerate

	assign timer0_clock_input = pinSync2_r[TIMER0_PIN];
	assign schmittSelA4       = 1'b1; // [R15]
	assign pullupEnA          = 6'h00;

	////////////////////////////////////////////////////////////////////////
	// open-drain: drive only while the output is low
	assign captureOe = captureDirOut & ~(captureOd_r[4:0] & captureOut); // [R04] [R22]
	assign serialOe  = serialDirOut & ~(serialOd_r[1:0] & serialOut); // [R04] [R22]
	assign spiOe     = spiDirOut & ~(spiOd_r[1:0] & spiOut); // [R04] [R22]

	// pull-up enables; target ports drop them per pin while driving
	assign port_b_pullup_enable_n = intCtrlTwo_r[PULLUP_B_BIT]; // [R01] [R02] [R23]
	assign port_d_pullup_enable   = portGUp_r[PULLUP_D_BIT]; // [R01] [R02]
	assign port_e_pullup_enable   = portGUp_r[PULLUP_E_BIT]; // [R01] [R02]
	assign port_j_pullup_enable   = portGUp_r[PULLUP_J_BIT]; // [R03]
	assign parallel_port_ttl_select = padBuf_r[PARALLEL_TTL_BIT]; // [R07]

endmodule // pad_port_ctrl

// >>> test/pad_port_checker.sv
// port-level assertions for the pad configuration and port A block
`timescale 1ns/10ps
module pad_port_checker
	import pad_port_pkg::*;
(
	// clock and reset
	input wire logic       core_clk,
	input wire logic       rst,
	input wire logic       clkEn,
	// register port
	input wire sfr_req_t   sfrReq,
	input wire logic [7:0] sfrRdata,
	input wire logic       sfrHit,
	// pads and peripherals
	input wire logic [2:0] oscillator_mode_code,
	input wire logic [7:0] padIn,
	input wire pad_drive_t padDrive,
	input wire logic [5:0] pullupEnA,
	input wire logic       timer0_clock_input,
	input wire logic [4:0] captureOut,
	input wire logic [4:0] captureDirOut,
	input wire logic [4:0] captureOe,
	input wire logic       schmittSelA4
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	wire logic oddRun = !oscillator_mode_code[2] && oscillator_mode_code[0] && clkEn;
	////////////////////////////////////////////////////////////////////////////////
	a_od_low_kept: assert property ((captureOe & ~captureOut) == (captureDirOut & ~captureOut))
		else $error("low output lost its drive");
	a_od_no_extra: assert property ((captureOe & ~captureDirOut) == 5'h0)
		else $error("drive enabled without peripheral");
	a_no_pullup_a: assert property (pullupEnA == 6'h0)
		else $error("pull-up on port A");
	a_schmitt_pin4: assert property (schmittSelA4)
		else $error("pin 4 buffer not Schmitt");
	a_timer0_sync: assert property ($past(clkEn) && $past(clkEn, 2) && !$past(rst) && !$past(rst, 2)
		|-> timer0_clock_input == $past(padIn[4], 2)) else $error("timer0 input wrong");
	a_read_hit: assert property (clkEn && sfrReq.sel == SEL_PORT_DIR |=> sfrHit)
		else $error("direction register not answered");
	a_reset_undriven: assert property ($fell(rst) |-> padDrive.oe[5:0] == 6'h0)
		else $error("pins driven after reset");
	a_quarter_clk: assert property (oddRun[*3] |-> padDrive.oe[6] &&
		padDrive.out[6] != $past(padDrive.out[6], 2)) else $error("clock out not quarter rate");
	a_ext_osc_free: assert property (oscillator_mode_code[2] |-> padDrive.oe[7:6] == 2'h0)
		else $error("oscillator pins driven");
	a_dir_mask: assert property (clkEn && oscillator_mode_code[2] && sfrReq.sel == SEL_PORT_DIR
		|=> sfrRdata[7:6] == 2'h0) else $error("oscillator pin bits not zero");
	c_quarter: cover property (oddRun[*3]);
	c_ext: cover property (oscillator_mode_code[2] && sfrReq.sel == SEL_PORT_DIR);
	c_refused: cover property (clkEn && sfrReq.sel == SEL_TIMER1_LOW ##1 !sfrHit);
endmodule // pad_port_checker

// >>> test/pin_partner.sv
// external logic on the port A pins
`timescale 1ns/10ps
module pin_partner
	import pad_port_pkg::*;
(
	input wire pad_drive_t padDrive,
	input wire logic [7:0] extVal,
	output logic [7:0]     padIn
);
	// block drive wins where enabled, otherwise the far side's value
	assign padIn = (padDrive.oe & padDrive.out) | (~padDrive.oe & extVal);
endmodule // pin_partner

// >>> test/tb_top.sv
// self-checking bench for pad configuration and port A control
`timescale 1ns/10ps
module tb_top;
	import pad_port_pkg::*;
	logic core_clk = 0, rst = 1, clkEn = 1, sfrHit, timer0_clock_input, schmittSelA4;
	logic port_b_pullup_enable_n, port_d_pullup_enable, port_e_pullup_enable;
	logic port_j_pullup_enable, parallel_port_ttl_select;
	sfr_req_t sfrReq = '0;
	pad_drive_t padDrive;
	logic [7:0] sfrRdata, padIn, q, ext = 8'h00;
	logic [2:0] oscillator_mode_code = 3'h1;
	logic [5:0] pullupEnA;
	logic [4:0] captureOut = '0, captureDirOut = '0, captureOe;
	logic [1:0] serialOut = '0, serialDirOut = '0, serialOe, spiOut = '0, spiDirOut = '0, spiOe;
	logic [7:0] mdl [16];
	int errors = 0, comparisons = 0, cycles = 0, seed = 79;
	always #2.5 core_clk = ~core_clk;
	pad_port_ctrl DUT (.core_clk, .rst, .clkEn, .sfrReq, .sfrRdata, .sfrHit, .oscillator_mode_code,
		.padIn, .padDrive, .pullupEnA, .timer0_clock_input, .captureOut, .serialOut, .spiOut,
		.captureOe, .serialOe, .spiOe, .captureDirOut, .serialDirOut, .spiDirOut,
		.port_b_pullup_enable_n, .port_d_pullup_enable, .port_e_pullup_enable,
		.port_j_pullup_enable, .parallel_port_ttl_select, .schmittSelA4);
	pin_partner partner (.padDrive, .extVal(ext), .padIn);
	////////////////////////////////////////////////////////////////////////////////
	task automatic stop_test();
		if (errors == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			errors++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// pins 6 and 7 read back only where the oscillator mode frees them
	function automatic logic [7:0] io();
		return oscillator_mode_code[2] ? 8'h3F : (oscillator_mode_code[0] ? 8'hBF : 8'hFF);
	endfunction
	function automatic logic [7:0] wm(input logic [3:0] s);
		case (s)
			4'h5: return 8'hE0;
			4'h7: return 8'h1F;
			4'h8, 4'h9: return 8'h03;
			4'hA: return 8'h01;
			default: return 8'hFF;
		endcase
	endfunction
	task automatic sfr(input logic [3:0] s, input logic w, input logic [7:0] d);
		logic ex;
		logic [7:0] pins;
		@(negedge core_clk);
		sfrReq = '{s, w, d};
		@(posedge core_clk);
		#1;
		q = sfrRdata;
		ex = (s inside {[4'h1:4'h6]}) || (mdl[6][4] && s inside {[4'h7:4'hB]});
		pins = ((mdl[2] & ext) | (~mdl[2] & mdl[3])) & io() & (mdl[11][0] ? 8'hFF : 8'hD0);
		chk({7'h0, sfrHit}, {7'h0, ex});
		if (!w && s != 4'hB)
			chk(q, ex ? (s == 4'h1 ? pins : (s inside {4'h2, 4'h3} ? mdl[s] & io() : mdl[s])) : 8'h00);
		if (w && ex)
			mdl[s == 4'h1 ? 4'h3 : s] = d & wm(s);
	endtask
	always @(posedge core_clk)
		if (++cycles == 5000)
		begin
			errors++;
			stop_test();
		end
	initial
	begin
		mdl = '{default: 8'h00};
		mdl[2] = 8'hFF;
		mdl[4] = 8'hFF;
		ext = 8'($random(seed));
		repeat (5) @(negedge core_clk);
		rst = 0;
		// pin synchroniser holds zero through reset; let it fill first
		repeat (2) @(negedge core_clk);
		// analog pins left as inputs while analog
		for (int s = 1; s < 13; s++)
			sfr(4'(s), 1'b0, 8'h00);
		sfr(4'h7, 1'b1, 8'hFF);
		sfr(4'h6, 1'b1, 8'h10);
		for (int s = 7; s < 11; s++)
		begin
			sfr(4'(s), 1'b1, 8'hFF);
			sfr(4'(s), 1'b0, 8'h00);
		end
		chk({7'h0, parallel_port_ttl_select}, 8'h01);
		sfr(4'hB, 1'b1, 8'hFF);
		sfr(4'h4, 1'b1, 8'h7F);
		sfr(4'h5, 1'b1, 8'hE0);
		chk({port_b_pullup_enable_n, port_d_pullup_enable, port_e_pullup_enable,
			port_j_pullup_enable, 4'h0}, 8'h70);
		for (int i = 0; i < 12; i++)
		begin
			for (int s = 7; s < 11; s++)
				sfr(4'(s), 1'b1, 8'($random(seed)));
			sfr(4'h2, 1'b1, 8'($random(seed)));
			sfr(i[0] ? 4'h1 : 4'h3, 1'b1, 8'($random(seed)));
			@(negedge core_clk);
			ext = 8'($random(seed));
			{captureOut, captureDirOut, serialOut, serialDirOut} = 14'($random(seed));
			{spiOut, spiDirOut} = 4'($random(seed));
			#1;
			chk({3'h0, captureOe}, {3'h0, captureDirOut & ~(captureOut & mdl[7][4:0])});
			chk({6'h0, serialOe}, {6'h0, serialDirOut & ~(serialOut & mdl[8][1:0])});
			chk({6'h0, spiOe}, {6'h0, spiDirOut & ~(spiOut & mdl[9][1:0])});
			chk(padDrive.oe & 8'h3F, ~mdl[2] & 8'h3F);
			chk(padDrive.out & ~mdl[2] & 8'h3F, mdl[3] & ~mdl[2] & 8'h3F);
			chk({7'h0, parallel_port_ttl_select}, {7'h0, mdl[10][0]});
			repeat (3) @(posedge core_clk);
			sfr(4'h1, 1'b0, 8'h00);
			sfr(4'h3, 1'b0, 8'h00);
		end
		sfr(4'h6, 1'b1, 8'h00);
		sfr(4'hA, 1'b0, 8'h00);
		// all inputs, so pin 6 drives only as clock out
		sfr(4'h2, 1'b1, 8'hFF);
		for (int k = 0; k < 8; k++)
		begin
			@(negedge core_clk);
			oscillator_mode_code = 3'(k % 5);
			sfr(4'h2, 1'b0, 8'h00);
			chk({7'h0, padDrive.oe[6]}, {7'h0, k % 5 == 1 || k % 5 == 3});
		end
		stop_test();
	end
endmodule // tb_top
bind pad_port_ctrl pad_port_checker chk (.core_clk, .rst, .clkEn, .sfrReq, .sfrRdata, .sfrHit,
	.oscillator_mode_code, .padIn, .padDrive, .pullupEnA, .timer0_clock_input, .captureOut,
	.captureDirOut, .captureOe, .schmittSelA4);
